// File: lcq_pkg.sv
// Shared constants and types for the line clock qualifier
package lcq_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] LCQ_CTRL_ADDR  = 8'h13;
    localparam logic [7:0] LCQ_CTRL_RESET = 8'h00;
    localparam logic [7:0] LCQ_UNMAPPED   = 8'h00;

    // ==========================================================
    // Control field positions
    localparam int LCQ_FREQ_SEL_BIT = 7;
    localparam int LCQ_DISABLE_BIT  = 6;
    localparam int LCQ_RP_LSB       = 4;
    localparam int LCQ_QC_LSB       = 2;
    localparam int LCQ_EB_LSB       = 0;

    // ==========================================================
    // Field encodings
    localparam logic [1:0] LCQ_QC_OFF     = 2'h0;
    localparam logic [1:0] LCQ_QC_ONE     = 2'h1;
    localparam logic [1:0] LCQ_QC_MID     = 2'h2;
    localparam logic [1:0] LCQ_EB_PER1    = 2'h0;
    localparam logic [1:0] LCQ_EB_PER2    = 2'h1;
    localparam logic [1:0] LCQ_EB_FIXED1  = 2'h2;
    localparam logic [1:0] LCQ_RP_2S      = 2'h0;
    localparam logic [1:0] LCQ_RP_4S      = 2'h1;
    localparam logic [1:0] LCQ_RP_8S      = 2'h2;

    // ==========================================================
    // Timebase figures
    localparam int XTAL_HZ    = 32768;
    localparam int LINE_HZ_60 = 60;
    localparam int LINE_HZ_50 = 50;

    localparam logic [14:0] LCQ_XTAL_HALF = 15'(XTAL_HZ / 2);
    localparam logic [5:0]  LCQ_HALF_60   = 6'(LINE_HZ_60 / 2);
    localparam logic [5:0]  LCQ_HALF_50   = 6'(LINE_HZ_50 / 2);

    // Line cycles measured per code
    localparam logic [3:0] LCQ_N_ONE = 4'h1;
    localparam logic [3:0] LCQ_N_60M = 4'h6;
    localparam logic [3:0] LCQ_N_60L = 4'hc;
    localparam logic [3:0] LCQ_N_50M = 4'h5;
    localparam logic [3:0] LCQ_N_50L = 4'ha;

    // Expected crystal count, rounded to nearest
    localparam logic [13:0] LCQ_EXP_60_1  = 14'((2*XTAL_HZ*1  + LINE_HZ_60) / (2*LINE_HZ_60));
    localparam logic [13:0] LCQ_EXP_60_6  = 14'((2*XTAL_HZ*6  + LINE_HZ_60) / (2*LINE_HZ_60));
    localparam logic [13:0] LCQ_EXP_60_12 = 14'((2*XTAL_HZ*12 + LINE_HZ_60) / (2*LINE_HZ_60));
    localparam logic [13:0] LCQ_EXP_50_1  = 14'((2*XTAL_HZ*1  + LINE_HZ_50) / (2*LINE_HZ_50));
    localparam logic [13:0] LCQ_EXP_50_5  = 14'((2*XTAL_HZ*5  + LINE_HZ_50) / (2*LINE_HZ_50));
    localparam logic [13:0] LCQ_EXP_50_10 = 14'((2*XTAL_HZ*10 + LINE_HZ_50) / (2*LINE_HZ_50));

    // Fixed budgets in crystal cycles
    localparam logic [4:0] LCQ_FIXED_ONE = 5'h01;
    localparam logic [4:0] LCQ_FIXED_TWO = 5'h02;

    // Recovery periods in seconds of crystal time
    localparam logic [4:0] LCQ_RECOV_2S  = 5'd2;
    localparam logic [4:0] LCQ_RECOV_4S  = 5'd4;
    localparam logic [4:0] LCQ_RECOV_8S  = 5'd8;
    localparam logic [4:0] LCQ_RECOV_16S = 5'd16;

    // ==========================================================
    // Qualifier states
    typedef enum logic [4:0] {
        LCQ_IDLE    = 5'b00001,
        LCQ_SYNC    = 5'b00010,
        LCQ_MEASURE = 5'b00100,
        LCQ_JUDGE   = 5'b01000,
        LCQ_RECOVER = 5'b10000
    } lcq_state_t;

endpackage : lcq_pkg

// File: lcq_edge_sync.sv
// Two-stage pin synchroniser with rising edge pulse
`timescale 1ns/1ps

module lcq_edge_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Pin and pulse
    input  wire logic pin_in,
    output logic      rise
);

    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;
    logic last_reg;
    logic last_next;
    logic rise_reg;
    logic rise_next;

    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
        last_next = sync_reg;
        rise_next = sync_reg & ~last_reg;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
            rise_reg <= rise_next;
        end
    end

    assign rise = rise_reg;

endmodule : lcq_edge_sync

// File: lcq_line_clock_qualifier.sv
// Line clock qualifier against the crystal timebase, with fallback and retest
//
// Functional notes
// - Select bit: 0 is 60 Hz, 1 is 50 Hz
// - Disable bit 1 stops using line clock
// - Disabled: timekeeping and output from crystal only
// - Recovery code gives 2, 4, 8, 16 seconds
// - After failure, retest after recovery period
// - Cycle code picks 1, 6/5, 12/10 cycles
// - Cycle code zero: no qualification at all
// - Count crystal cycles within measured line cycles
// - Compare absolute count error against chosen budget
// - Error over budget sets fail, else clears
// - Budget codes 00/01: 1 or 2 per cycle
// - Budget codes 10/11: fixed 1 or 2 total
// - Failed qualification: 1 Hz output from crystal
`timescale 1ns/1ps

module lcq_line_clock_qualifier (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Clock pins
    input  wire logic       line_clk_pin,
    input  wire logic       xtal_clk_pin,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Status and timebase
    output logic            line_clock_fail,
    output logic            use_line_clock,
    output logic            sec_tick,
    output logic            freq_output_pin
);

    // ==========================================================
    // Pin synchronisers
    logic line_rise;
    logic xtal_rise;

    lcq_edge_sync u_line_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pin_in  (line_clk_pin),
        .rise    (line_rise)
    );

    lcq_edge_sync u_xtal_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pin_in  (xtal_clk_pin),
        .rise    (xtal_rise)
    );

    // ==========================================================
    // Control register
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       addr_hit;

    always_comb begin
        addr_hit   = (reg_addr == lcq_pkg::LCQ_CTRL_ADDR);
        ctrl_next  = ctrl_reg;
        rdata_next = rdata_reg;
        if (reg_wr && addr_hit) begin
            ctrl_next = reg_wdata;
        end
        if (reg_rd) begin
            rdata_next = addr_hit ? ctrl_reg : lcq_pkg::LCQ_UNMAPPED;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg  <= lcq_pkg::LCQ_CTRL_RESET;
            rdata_reg <= lcq_pkg::LCQ_UNMAPPED;
        end else begin
            ctrl_reg  <= ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    // Field views
    logic       sel_50hz;
    logic       line_clock_disable;
    logic [1:0] recovery_period_sel;
    logic [1:0] qual_cycle_sel;
    logic [1:0] error_budget_sel;

    always_comb begin
        sel_50hz            = ctrl_reg[lcq_pkg::LCQ_FREQ_SEL_BIT];
        line_clock_disable  = ctrl_reg[lcq_pkg::LCQ_DISABLE_BIT];
        recovery_period_sel = ctrl_reg[lcq_pkg::LCQ_RP_LSB +: 2];
        qual_cycle_sel      = ctrl_reg[lcq_pkg::LCQ_QC_LSB +: 2];
        error_budget_sel    = ctrl_reg[lcq_pkg::LCQ_EB_LSB +: 2];
    end

    // ==========================================================
    // Measurement targets
    logic [3:0]  n_cycles;
    logic [13:0] exp_count;
    logic [4:0]  budget;
    logic [4:0]  recov_secs;
    logic [5:0]  line_half;
    logic [14:0] fail_limit;

    always_comb begin
        case (qual_cycle_sel)
            lcq_pkg::LCQ_QC_ONE: begin
                n_cycles  = lcq_pkg::LCQ_N_ONE;
                exp_count = sel_50hz ? lcq_pkg::LCQ_EXP_50_1 : lcq_pkg::LCQ_EXP_60_1;
            end
            lcq_pkg::LCQ_QC_MID: begin
                n_cycles  = sel_50hz ? lcq_pkg::LCQ_N_50M : lcq_pkg::LCQ_N_60M;
                exp_count = sel_50hz ? lcq_pkg::LCQ_EXP_50_5 : lcq_pkg::LCQ_EXP_60_6;
            end
            default: begin
                n_cycles  = sel_50hz ? lcq_pkg::LCQ_N_50L : lcq_pkg::LCQ_N_60L;
                exp_count = sel_50hz ? lcq_pkg::LCQ_EXP_50_10 : lcq_pkg::LCQ_EXP_60_12;
            end
        endcase
        case (error_budget_sel)
            lcq_pkg::LCQ_EB_PER1:   budget = {1'b0, n_cycles};
            lcq_pkg::LCQ_EB_PER2:   budget = {n_cycles, 1'b0};
            lcq_pkg::LCQ_EB_FIXED1: budget = lcq_pkg::LCQ_FIXED_ONE;
            default:                budget = lcq_pkg::LCQ_FIXED_TWO;
        endcase
        case (recovery_period_sel)
            lcq_pkg::LCQ_RP_2S: recov_secs = lcq_pkg::LCQ_RECOV_2S;
            lcq_pkg::LCQ_RP_4S: recov_secs = lcq_pkg::LCQ_RECOV_4S;
            lcq_pkg::LCQ_RP_8S: recov_secs = lcq_pkg::LCQ_RECOV_8S;
            default:            recov_secs = lcq_pkg::LCQ_RECOV_16S;
        endcase
        line_half  = sel_50hz ? lcq_pkg::LCQ_HALF_50 : lcq_pkg::LCQ_HALF_60;
        fail_limit = {1'b0, exp_count} + {10'h000, budget};
    end

    // ==========================================================
    // Timebases: crystal and line, each a 1 Hz square and a second pulse
    logic [14:0] xdiv_reg;
    logic [14:0] xdiv_next;
    logic        xphase_reg;
    logic        xphase_next;
    logic        xsec;
    logic [5:0]  ldiv_reg;
    logic [5:0]  ldiv_next;
    logic        lphase_reg;
    logic        lphase_next;
    logic        lsec;
    logic        tick_reg;
    logic        tick_next;
    logic        sqw_reg;
    logic        sqw_next;
    logic        line_src_reg;

    always_comb begin
        xdiv_next   = xdiv_reg;
        xphase_next = xphase_reg;
        xsec        = 1'b0;
        ldiv_next   = ldiv_reg;
        lphase_next = lphase_reg;
        lsec        = 1'b0;
        if (xtal_rise) begin
            if (xdiv_reg >= lcq_pkg::LCQ_XTAL_HALF - 15'h0001) begin
                xdiv_next   = 15'h0000;
                xphase_next = ~xphase_reg;
                xsec        = xphase_reg;
            end else begin
                xdiv_next = xdiv_reg + 15'h0001;
            end
        end
        // A changed frequency select keeps the count; a count past the new half ends it on the next line edge
        if (line_rise) begin
            if (ldiv_reg >= line_half - 6'h01) begin
                ldiv_next   = 6'h00;
                lphase_next = ~lphase_reg;
                lsec        = lphase_reg;
            end else begin
                ldiv_next = ldiv_reg + 6'h01;
            end
        end
        tick_next = line_src_reg ? lsec : xsec;
        sqw_next  = line_src_reg ? lphase_reg : xphase_reg;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            xdiv_reg   <= 15'h0000;
            xphase_reg <= 1'b0;
            ldiv_reg   <= 6'h00;
            lphase_reg <= 1'b0;
            tick_reg   <= 1'b0;
            sqw_reg    <= 1'b0;
        end else begin
            xdiv_reg   <= xdiv_next;
            xphase_reg <= xphase_next;
            ldiv_reg   <= ldiv_next;
            lphase_reg <= lphase_next;
            tick_reg   <= tick_next;
            sqw_reg    <= sqw_next;
        end
    end

    // ==========================================================
    // Qualification sequencer
    lcq_pkg::lcq_state_t state_reg;
    lcq_pkg::lcq_state_t state_next;
    logic [3:0]  lcnt_reg;
    logic [3:0]  lcnt_next;
    logic [13:0] xcnt_reg;
    logic [13:0] xcnt_next;
    logic [4:0]  rcnt_reg;
    logic [4:0]  rcnt_next;
    logic        fail_reg;
    logic        fail_next;
    logic        line_src_next;
    logic        qual_on;
    logic [13:0] abs_err;

    always_comb begin
        state_next    = state_reg;
        lcnt_next     = lcnt_reg;
        xcnt_next     = xcnt_reg;
        rcnt_next     = rcnt_reg;
        fail_next     = fail_reg;
        line_src_next = line_src_reg;
        qual_on       = ~line_clock_disable && (qual_cycle_sel != lcq_pkg::LCQ_QC_OFF);
        abs_err       = (xcnt_reg >= exp_count) ? (xcnt_reg - exp_count)
                                                : (exp_count - xcnt_reg);
        case (state_reg)
            lcq_pkg::LCQ_IDLE: begin
                fail_next     = 1'b0;
                line_src_next = ~line_clock_disable;
                if (qual_on) begin
                    state_next = lcq_pkg::LCQ_SYNC;
                end
            end
            lcq_pkg::LCQ_SYNC: begin
                // Window opens on a line edge so whole cycles are timed
                if (line_rise) begin
                    lcnt_next  = 4'h0;
                    xcnt_next  = 14'h0000;
                    state_next = lcq_pkg::LCQ_MEASURE;
                end
            end
            lcq_pkg::LCQ_MEASURE: begin
                if (xtal_rise && xcnt_reg != 14'h3fff) begin
                    xcnt_next = xcnt_reg + 14'h0001;
                end
                if (line_rise) begin
                    lcnt_next = lcnt_reg + 4'h1;
                    if (lcnt_reg + 4'h1 >= n_cycles) begin
                        state_next = lcq_pkg::LCQ_JUDGE;
                    end
                end
                // A dead line input must not hang the window
                if ({1'b0, xcnt_reg} > fail_limit) begin
                    state_next = lcq_pkg::LCQ_JUDGE;
                end
            end
            lcq_pkg::LCQ_JUDGE: begin
                if (abs_err > {9'h000, budget}) begin
                    fail_next     = 1'b1;
                    line_src_next = 1'b0;
                    rcnt_next     = 5'h00;
                    state_next    = lcq_pkg::LCQ_RECOVER;
                end else begin
                    fail_next     = 1'b0;
                    line_src_next = 1'b1;
                    state_next    = lcq_pkg::LCQ_SYNC;
                end
            end
            lcq_pkg::LCQ_RECOVER: begin
                if (xsec) begin
                    rcnt_next = rcnt_reg + 5'h01;
                    if (rcnt_reg + 5'h01 >= recov_secs) begin
                        state_next = lcq_pkg::LCQ_SYNC;
                    end
                end
            end
            default: begin
                state_next = lcq_pkg::LCQ_IDLE;
            end
        endcase
        if (!qual_on) begin
            state_next = lcq_pkg::LCQ_IDLE;
            fail_next  = 1'b0;
            if (line_clock_disable) begin
                line_src_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg    <= lcq_pkg::LCQ_IDLE;
            lcnt_reg     <= 4'h0;
            xcnt_reg     <= 14'h0000;
            rcnt_reg     <= 5'h00;
            fail_reg     <= 1'b0;
            line_src_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            lcnt_reg     <= lcnt_next;
            xcnt_reg     <= xcnt_next;
            rcnt_reg     <= rcnt_next;
            fail_reg     <= fail_next;
            line_src_reg <= line_src_next;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata       = rdata_reg;
    assign line_clock_fail = fail_reg;
    assign use_line_clock  = line_src_reg;
    assign sec_tick        = tick_reg;
    assign freq_output_pin = sqw_reg;

endmodule : lcq_line_clock_qualifier

// File: lcq_line_clock_qualifier_assertions.sv
// Port checker for the line clock qualifier
`timescale 1ns/1ps

module lcq_checker (
    // Clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // Pins and register port
    input wire logic       line_clk_pin,
    input wire logic       xtal_clk_pin,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Status and timebase
    input wire logic       line_clock_fail,
    input wire logic       use_line_clock,
    input wire logic       sec_tick,
    input wire logic       freq_output_pin
);
    // ==========================================================
    // Shadow of the control register
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (reg_wr && reg_addr == lcq_pkg::LCQ_CTRL_ADDR) begin
            ctrl_next = reg_wdata;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= lcq_pkg::LCQ_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Assertions
    a_ctrl_read_back: assert property (
        reg_rd && reg_addr == 8'h13 |=> reg_rdata == $past(ctrl_reg))
        else $error("Control read data wrong");
    a_other_reads_zero: assert property (
        reg_rd && reg_addr != 8'h13 |=> reg_rdata == 8'h00)
        else $error("Unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("Read data moved without a read");
    // Depth 3 leaves room for the write to reach the outputs
    a_disable_no_line: assert property (
        ctrl_reg[6] && $past(ctrl_reg[6], 3) |-> !use_line_clock && !line_clock_fail)
        else $error("Line clock used while disabled");
    a_qual_off_pass: assert property (
        ctrl_reg[3:2] == 2'h0 && $past(ctrl_reg[3:2], 3) == 2'h0 |-> !line_clock_fail)
        else $error("Fail flag with qualification off");
    a_fail_on_crystal: assert property (
        line_clock_fail |-> !use_line_clock)
        else $error("Line clock used while failed");
    a_fail_needs_qual: assert property (
        $rose(line_clock_fail) |-> $past(ctrl_reg[3:2]) != 2'h0 && !$past(ctrl_reg[6]))
        else $error("Fail raised without qualification");
    a_good_uses_line: assert property (
        !$past(sys_rst, 3) && !ctrl_reg[6] && !$past(ctrl_reg[6], 3) && !line_clock_fail
        && !$past(line_clock_fail) |-> use_line_clock)
        else $error("Healthy line clock not in use");

    a_tick_on_high: assert property (
        sec_tick |-> freq_output_pin ##1 !freq_output_pin)
        else $error("Second tick off the falling square edge");

    c_fail_seen: cover property ($rose(line_clock_fail));
    c_sec_tick: cover property (sec_tick);
    c_disabled: cover property (ctrl_reg[6] && !use_line_clock);
    c_ctrl_read: cover property (reg_rd && reg_addr == 8'h13);
endmodule : lcq_checker

// File: lcq_line_model.sv
// Mains line and crystal pin source for the qualifier
`timescale 1ns/1ps

module lcq_line_model (
    // Line period in crystal periods
    input  wire logic [15:0] line_xtal,
    // Clock pins
    output logic             line_clk_pin,
    output logic             xtal_clk_pin
);
    // Crystal sped up to 40 ns so windows fit the run; skewed off the system edges
    localparam int XTAL_HALF_NS = 20;

    initial begin
        xtal_clk_pin = 1'b0;
        #3;
        forever begin
            #(XTAL_HALF_NS) xtal_clk_pin = ~xtal_clk_pin;
        end
    end

    // Runs free like a mains wave; each half takes the period in force
    initial begin
        line_clk_pin = 1'b0;
        // Lets the bench set the period before the first half is timed
        #1;
        forever begin
            #(line_xtal * XTAL_HALF_NS) line_clk_pin = 1'b1;
            #(line_xtal * XTAL_HALF_NS) line_clk_pin = 1'b0;
        end
    end
endmodule : lcq_line_model

// File: tb_lcq_line_clock_qualifier.sv
// Self-checking bench for the line clock qualifier
`timescale 1ns/1ps

module tb_lcq_line_clock_qualifier;
    // ==========================================================
    // Signals
    logic        clock;
    logic        sys_rst;
    logic        line_clk_pin;
    logic        xtal_clk_pin;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        line_clock_fail;
    logic        use_line_clock;
    logic        sec_tick;
    logic        freq_output_pin;
    logic [15:0] line_xtal;
    logic [7:0]  half_n;
    int          errors;
    int          n_tests;

    always #5 clock = ~clock;

    lcq_line_clock_qualifier i_dut (
        .clock(clock), .sys_rst(sys_rst), .line_clk_pin(line_clk_pin),
        .xtal_clk_pin(xtal_clk_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .line_clock_fail(line_clock_fail), .use_line_clock(use_line_clock),
        .sec_tick(sec_tick), .freq_output_pin(freq_output_pin));

    lcq_line_model i_line (
        .line_xtal(line_xtal), .line_clk_pin(line_clk_pin), .xtal_clk_pin(xtal_clk_pin));

    // ==========================================================
    // Tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        reg_wr    = 1'b1;
        reg_addr  = addr;
        reg_wdata = data;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clock);
        reg_rd   = 1'b1;
        reg_addr = addr;
        @(negedge clock);
        reg_rd = 1'b0;
        @(negedge clock);
        check(reg_rdata, exp);
    endtask : rd

    task automatic status(input logic fail_exp);
        check({7'h00, line_clock_fail}, {7'h00, fail_exp});
        check({7'h00, use_line_clock}, {7'h00, ~fail_exp});
    endtask : status

    // Cycles between two edges of the 1 Hz output, saturating; 0 if it never moves
    task automatic pin_half(input int limit, output logic [7:0] n);
        int   i;
        int   k;
        logic last;
        k    = 0;
        n    = 8'h00;
        last = freq_output_pin;
        for (i = 0; i < limit && k < 2; i++) begin
            @(negedge clock);
            if (k == 1 && n != 8'hff) begin
                n++;
            end
            if (freq_output_pin !== last) begin
                k++;
                last = freq_output_pin;
            end
        end
    endtask : pin_half

    // Qualification is parked first so no stale window is judged
    task automatic qual(input logic [7:0] ctrl, input logic [15:0] per,
                        input logic fail_exp, input int cyc);
        int i;
        wr(lcq_pkg::LCQ_CTRL_ADDR, ctrl & 8'hf3);
        line_xtal = per;
        repeat (10) @(negedge clock);
        wr(lcq_pkg::LCQ_CTRL_ADDR, ctrl);
        for (i = 0; i < cyc && line_clock_fail !== 1'b1; i++) begin
            @(negedge clock);
        end
        status(fail_exp);
        rd(lcq_pkg::LCQ_CTRL_ADDR, ctrl);
        $display("Test done: ctrl %h line period %0d", ctrl, per);
    endtask : qual

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Main sequence
    initial begin
        clock     = 1'b0;
        sys_rst   = 1'b1;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        line_xtal = 16'd546;
        errors    = 0;
        n_tests   = 0;
        repeat (20) @(negedge clock);
        sys_rst = 1'b0;
        repeat (2) @(negedge clock);
        rd(lcq_pkg::LCQ_CTRL_ADDR, lcq_pkg::LCQ_CTRL_RESET);
        status(1'b0);
        wr(8'h12, 8'hff);
        rd(8'h12, 8'h00);
        rd(lcq_pkg::LCQ_CTRL_ADDR, 8'h00);
        $display("Test done: reset and register map");
        // Fast line of 8 clocks a cycle; crystal half second lies far beyond the run
        line_xtal = 16'd2;
        pin_half(2000, half_n);
        check(half_n, 8'(lcq_pkg::LINE_HZ_60 / 2 * 8));
        wr(lcq_pkg::LCQ_CTRL_ADDR, 8'h80);
        pin_half(600, half_n);
        check(half_n, 8'(lcq_pkg::LINE_HZ_50 / 2 * 8));
        wr(lcq_pkg::LCQ_CTRL_ADDR, 8'hc0);
        repeat (5) @(negedge clock);
        pin_half(600, half_n);
        check(half_n, 8'h00);
        $display("Test done: fast line timebase");
        // Count errors 1, 5 and 16 against budgets 2, 6 and 20
        qual(8'h07, 16'd547, 1'b0, 5000);
        qual(8'h08, 16'd547, 1'b0, 16500);
        qual(8'h8d, 16'd657, 1'b0, 30000);
        qual(8'h86, 16'd546, 1'b1, 6000);
        // Recovery is seconds of crystal time, so the flag must still stand
        repeat (6000) @(negedge clock);
        status(1'b1);
        qual(8'h80, 16'd546, 1'b0, 50);
        wr(lcq_pkg::LCQ_CTRL_ADDR, 8'hc7);
        repeat (5) @(negedge clock);
        check({7'h00, use_line_clock}, 8'h00);
        check({7'h00, line_clock_fail}, 8'h00);
        rd(lcq_pkg::LCQ_CTRL_ADDR, 8'hc7);
        $display("Test done: line clock disabled");
        print_verdict();
    end
endmodule : tb_lcq_line_clock_qualifier

bind lcq_line_clock_qualifier lcq_checker i_checker (
    .clock(clock), .sys_rst(sys_rst), .line_clk_pin(line_clk_pin),
    .xtal_clk_pin(xtal_clk_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .line_clock_fail(line_clock_fail), .use_line_clock(use_line_clock),
    .sec_tick(sec_tick), .freq_output_pin(freq_output_pin));
